// ### peil_top.sv
// Purpose: external interrupt logic of an 8-bit port, six- or eight-channel variant
// Assumes: pins synchronous to clk; one-cycle read and write strobes, never together
// Notes: variant chosen by parameter; event status and mask registers added beside it
// Function
// [RULE1] six-channel: enable bit 7 is one edge select shared by channels 2 to 5
// [RULE2] six-channel: shared bit 0 means rising, 1 means falling, for channels 2-5
// [RULE3] six-channel: enable bit 6 selects edge for channels 0,1; 0 rising, 1 falling
// [RULE4] six-channel: enable bits 5 to 0 each enable their own channel
// [RULE5] six-channel: flag bits 7 and 6 are read-only zero
// [RULE6] six-channel: flags 2-5 set on the edge chosen by enable bit 7
// [RULE7] six-channel: flags 0,1 set on the edge chosen by enable bit 6
// [RULE8] a flag stays set until software writes 0; only reset clears otherwise
// [RULE9] software writing 1 sets a flag and requests like an edge if enabled
// [RULE10] eight-channel: enable bits 7 to 0 each enable their own channel
// [RULE11] eight-channel: edge register, one bit per channel, 0 rising, 1 falling
// [RULE12] eight-channel: each flag sets on its own pin's selected edge
// [RULE13] six-channel: at most six pins interrupt-capable, own flag and enable each
// [RULE14] eight-channel variant gives the per-pin interrupt function on all pins
// [RULE15] pins sampled on clk, edge from previous sample; request while flag and enable
// [RULE16] a hardware set wins over a same-cycle software flag write
`timescale 1ns/1ps
`include "peil_consts.svh"

module peil_top #(
	parameter peil_pkg::peil_variant_t VARIANT = peil_pkg::PEIL_SIX
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// register port
	input wire logic [`PEIL_AW-1:0] addr,
	input wire logic [`PEIL_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [`PEIL_W-1:0] rdata,
	// port pins
	input wire logic [`PEIL_W-1:0] ext_irq_pin,
	// requests
	output logic ext_irq_req,
	output logic irq
);
	import peil_pkg::*;

	peil_st_t st_r;
	peil_st_t st_nxt;

	logic is_eight;
	logic [`PEIL_W-1:0] chan_mask;
	logic [`PEIL_W-1:0] six_sel;
	logic [`PEIL_W-1:0] fall_sel;
	logic [`PEIL_W-1:0] raw_hit;
	logic [`PEIL_W-1:0] hit_eff;
	logic [`PEIL_W-1:0] det_prev;
	logic det_armed;
	logic [`PEIL_W-1:0] rd_val;
	logic wr_en;
	logic wr_flag;
	logic wr_edge;
	logic wr_stat_clr;
	logic wr_ien;

	// variant decode
	assign is_eight = (VARIANT == PEIL_EIGHT); // [RULE14]
	// pins 7 and 6 of the six-channel port carry no interrupt at all
	assign chan_mask = is_eight ? `PEIL_MASK_EIGHT : `PEIL_MASK_SIX; // [RULE13]

	// shared selects of the six-channel port, spread out to one bit per channel
	for (genvar gi = 0; gi < `PEIL_W; gi++) begin : g_six_sel
		if (gi < `PEIL_LO_GRP_N) begin : g_lo
			assign six_sel[gi] = st_r.en[`PEIL_SEL_LO_BIT]; // [RULE3]
		end else begin : g_hi
			assign six_sel[gi] = st_r.en[`PEIL_SEL_HI_BIT]; // [RULE1] [RULE2]
		end
	end

	assign fall_sel = is_eight ? st_r.edge_sel : six_sel; // [RULE11]

	peil_edge_det u_det (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.pin(ext_irq_pin),
		.fall_sel(fall_sel),
		.hit(raw_hit),
		.prev(det_prev),
		.armed(det_armed)
	);

	// only existing channels may raise a flag
	assign hit_eff = raw_hit & chan_mask; // [RULE6] [RULE7] [RULE12]

	// register write decode
	assign wr_en = wr && (addr == `PEIL_ADDR_ENABLE);
	assign wr_flag = wr && (addr == `PEIL_ADDR_FLAG);
	assign wr_edge = wr && (addr == `PEIL_ADDR_EDGE) && is_eight;
	assign wr_stat_clr = wr && (addr == `PEIL_ADDR_CLEAR);
	assign wr_ien = wr && (addr == `PEIL_ADDR_IEN);

	// read mux; unmapped and write-only addresses read zero
	always_comb begin
		case (addr)
			`PEIL_ADDR_ENABLE: rd_val = st_r.en;
			`PEIL_ADDR_FLAG: rd_val = st_r.flag & chan_mask; // [RULE5]
			`PEIL_ADDR_EDGE: rd_val = is_eight ? st_r.edge_sel : '0;
			`PEIL_ADDR_STAT: rd_val = st_r.stat;
			`PEIL_ADDR_IEN: rd_val = st_r.ien;
			default: rd_val = '0;
		endcase
	end

	// next state; nothing moves while ce is low
	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.rdata = rd ? rd_val : '0;
			if (wr_en) begin
				st_nxt.en = wdata; // [RULE4] [RULE10]
			end
			if (wr_edge) begin
				st_nxt.edge_sel = wdata; // [RULE11]
			end
			if (wr_ien) begin
				st_nxt.ien = wdata;
			end
			// a written 0 clears, a written 1 sets; hardware never clears
			if (wr_flag) begin
				st_nxt.flag = wdata & chan_mask; // [RULE8] [RULE9] [RULE5]
			end
			// edge set is ored in last so it wins over the write
			st_nxt.flag = st_nxt.flag | hit_eff; // [RULE16] [RULE6] [RULE7] [RULE12]
			// event status, set wins over clear
			st_nxt.stat = (st_r.stat & ~(wr_stat_clr ? wdata : '0)) | hit_eff;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r.en <= `PEIL_RST_ENABLE;
			st_r.flag <= `PEIL_RST_FLAG;
			st_r.edge_sel <= `PEIL_RST_EDGE;
			st_r.stat <= `PEIL_RST_STAT;
			st_r.ien <= `PEIL_RST_IEN;
			st_r.rdata <= `PEIL_RST_RDATA;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;
	// request follows the flag, whether an edge or software set it
	assign ext_irq_req = |(st_r.flag & st_r.en & chan_mask); // [RULE15] [RULE9] [RULE4] [RULE10]
	assign irq = |(st_r.stat & st_r.ien);

	// checks
	localparam int CH_LO = 0;
	localparam int CH_HI = 2;
	localparam int CH_TOP = 7;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence s_rise_hi_six;
		ce && det_armed && !is_eight && st_r.en[`PEIL_SEL_HI_BIT] == 1'b0
			&& !det_prev[CH_HI] && ext_irq_pin[CH_HI];
	endsequence

	sequence s_fall_hi_six;
		ce && det_armed && !is_eight && st_r.en[`PEIL_SEL_HI_BIT] == 1'b1
			&& det_prev[CH_HI] && !ext_irq_pin[CH_HI];
	endsequence

	sequence s_fall_lo_six;
		ce && det_armed && !is_eight && st_r.en[`PEIL_SEL_LO_BIT] == 1'b1
			&& det_prev[CH_LO] && !ext_irq_pin[CH_LO];
	endsequence

	sequence s_fall_top_eight;
		ce && det_armed && is_eight && st_r.edge_sel[CH_TOP] == 1'b1
			&& det_prev[CH_TOP] && !ext_irq_pin[CH_TOP];
	endsequence

	sequence s_sw_set_enabled;
		ce && wr_flag && ((wdata & st_r.en & chan_mask) != '0) && !wr_en;
	endsequence

	AST_RISE_HI_SIX: assert property (s_rise_hi_six |=> st_r.flag[CH_HI]) // [RULE2]
		else $error("rising edge on channel 2 did not set its flag");

	AST_FALL_HI_SIX: assert property (s_fall_hi_six |=> st_r.flag[CH_HI]) // [RULE6]
		else $error("falling edge on channel 2 did not set its flag");

	AST_FALL_LO_SIX: assert property (s_fall_lo_six |=> st_r.flag[CH_LO]) // [RULE7]
		else $error("falling edge on channel 0 did not set its flag");

	AST_RISE_IGNORED_HI: assert property ( // [RULE1]
		(ce && det_armed && !is_eight && st_r.en[`PEIL_SEL_HI_BIT]
			&& !det_prev[CH_HI] && ext_irq_pin[CH_HI]) |-> !hit_eff[CH_HI])
		else $error("rising edge hit channel 2 while falling edge selected");

	AST_LO_SEL_SEPARATE: assert property ( // [RULE3]
		(!is_eight && st_r.en[`PEIL_SEL_LO_BIT] != st_r.en[`PEIL_SEL_HI_BIT])
			|-> fall_sel[CH_LO] != fall_sel[CH_HI])
		else $error("channels 0 and 2 do not follow separate edge selects");

	AST_FALL_TOP_EIGHT: assert property (s_fall_top_eight |=> st_r.flag[CH_TOP]) // [RULE12]
		else $error("falling edge on channel 7 did not set its flag");

	AST_EIGHT_OWN_SEL: assert property (is_eight |-> fall_sel == st_r.edge_sel) // [RULE11]
		else $error("eight-channel edge select not taken per channel");

	AST_RSVD_ZERO: assert property (!is_eight |-> st_r.flag[CH_TOP:`PEIL_SEL_LO_BIT] == '0) // [RULE5]
		else $error("reserved flag bits of six-channel port became set");

	AST_SIX_NO_TOP: assert property (!is_eight |-> hit_eff[CH_TOP] == 1'b0) // [RULE13]
		else $error("six-channel port detected an edge on pin 7");

	AST_FLAG_HOLD: assert property ( // [RULE8]
		(ce && !wr_flag) |=> ((st_r.flag & $past(st_r.flag)) == $past(st_r.flag)))
		else $error("flag cleared without a software write");

	AST_FROZEN: assert property (!ce |=> $stable(st_r.flag) && $stable(st_r.en)) // [RULE8]
		else $error("state moved while clock enable was low");

	AST_SW_SET: assert property ( // [RULE9]
		(ce && wr_flag) |=> ((st_r.flag & ($past(wdata) & chan_mask))
			== ($past(wdata) & chan_mask)))
		else $error("software write of 1 did not set the flag");

	AST_SW_REQ: assert property (s_sw_set_enabled |=> ext_irq_req) // [RULE9]
		else $error("software-set enabled flag raised no request");

	AST_SET_WINS: assert property ( // [RULE16]
		(ce && wr_flag && (hit_eff != '0)) |=> ((st_r.flag & $past(hit_eff)) == $past(hit_eff)))
		else $error("edge lost against a same-cycle flag write");

	// disabling every set channel must drop the request on the next cycle
	AST_DISABLED_QUIET: assert property ( // [RULE4]
		(ce && wr_en && hit_eff == '0 && (st_r.flag & wdata & chan_mask) == '0)
			|=> !ext_irq_req)
		else $error("request raised with no enabled flag");

	AST_ENABLE_WRITE: assert property ((ce && wr_en) |=> st_r.en == $past(wdata)) // [RULE10]
		else $error("enable register did not take the written value");

	AST_EDGE_TO_REQ: assert property ( // [RULE15]
		(ce && (hit_eff & st_r.en) != '0 && !wr_en) |=> ext_irq_req)
		else $error("enabled edge did not raise a request next cycle");

	AST_EIGHT_ALL: assert property ( // [RULE14]
		(is_eight && ce && det_armed && st_r.edge_sel == '0
			&& det_prev == '0 && ext_irq_pin != '0) |=> st_r.flag != '0)
		else $error("eight-channel rising edges left all flags clear");

	sequence s_rise_lo_six;
		ce && det_armed && !is_eight && st_r.en[`PEIL_SEL_LO_BIT] == 1'b0
			&& !det_prev[CH_LO] && ext_irq_pin[CH_LO];
	endsequence

	sequence s_rise_top_eight;
		ce && det_armed && is_eight && st_r.edge_sel[CH_TOP] == 1'b0
			&& !det_prev[CH_TOP] && ext_irq_pin[CH_TOP];
	endsequence

	AST_RISE_LO_SIX: assert property (s_rise_lo_six |=> st_r.flag[CH_LO]) // [RULE3] [RULE7]
		else $error("rising edge on channel 0 did not set its flag");

	AST_RISE_TOP_EIGHT: assert property (s_rise_top_eight |=> st_r.flag[CH_TOP]) // [RULE12]
		else $error("rising edge on channel 7 did not set its flag");

	AST_SIX_NO_EDGE_REG: assert property (!is_eight |-> st_r.edge_sel == '0) // [RULE11]
		else $error("six-channel port took an edge select write");

	AST_EDGE_WRITE: assert property ((ce && wr_edge) |=> st_r.edge_sel == $past(wdata)) // [RULE11]
		else $error("edge select register did not take the written value");

	// no edge can be judged before the sampler holds a real pin value
	AST_NOT_ARMED: assert property (!det_armed |-> raw_hit == '0) // [RULE15]
		else $error("edge reported before the first pin sample");

	AST_ARMED_STAYS: assert property (det_armed |=> det_armed) // [RULE15]
		else $error("edge sampler lost its first sample");

	AST_SAMPLE: assert property (ce |=> det_prev == $past(ext_irq_pin)) // [RULE15]
		else $error("pin sample not taken on an enabled clock");

	AST_FROZEN_SAMPLE: assert property ( // [RULE15]
		!ce |=> $stable(det_prev) && $stable(st_r.rdata))
		else $error("sampler or read data moved while clock enable was low");

	AST_RD_ENABLE: assert property ( // [RULE4] [RULE10]
		(ce && rd && addr == `PEIL_ADDR_ENABLE) |=> rdata == $past(st_r.en))
		else $error("enable read did not return the enable register");

	AST_RD_FLAG: assert property ( // [RULE5]
		(ce && rd && addr == `PEIL_ADDR_FLAG) |=> rdata == ($past(st_r.flag) & chan_mask))
		else $error("flag read did not return the masked flags");

	AST_RD_EDGE: assert property ( // [RULE11]
		(ce && rd && addr == `PEIL_ADDR_EDGE) |=> rdata == (is_eight ? $past(st_r.edge_sel) : '0))
		else $error("edge select read returned a wrong value");

	AST_STAT_SET_WINS: assert property ( // [RULE16]
		(ce && wr_stat_clr && hit_eff != '0) |=> (st_r.stat & $past(hit_eff)) == $past(hit_eff))
		else $error("event status lost against a same-cycle clear");

	// per-channel checks; pins without a channel are held off by chan_mask
	for (genvar gc = 0; gc < `PEIL_W; gc++) begin : g_chk
		AST_CH_SET: assert property ( // [RULE6] [RULE7] [RULE12]
			(ce && hit_eff[gc]) |=> st_r.flag[gc])
			else $error("detected edge did not set its channel flag");

		AST_CH_WIN: assert property ( // [RULE16]
			(ce && wr_flag && !wdata[gc] && hit_eff[gc]) |=> st_r.flag[gc])
			else $error("same-cycle clear beat a detected edge");

		AST_CH_CLEAR: assert property ( // [RULE8]
			(ce && wr_flag && !wdata[gc] && !hit_eff[gc]) |=> !st_r.flag[gc])
			else $error("software write of 0 did not clear the flag");

		AST_CH_HOLD: assert property ( // [RULE8]
			(ce && !wr_flag && st_r.flag[gc]) |=> st_r.flag[gc])
			else $error("flag dropped without a software write");

		AST_CH_SW_SET: assert property ( // [RULE9]
			(ce && wr_flag && wdata[gc] && chan_mask[gc]) |=> st_r.flag[gc])
			else $error("software write of 1 left the channel flag clear");

		AST_CH_DEAD: assert property (!chan_mask[gc] |-> !st_r.flag[gc]) // [RULE13]
			else $error("flag set on a pin without an interrupt channel");

		AST_CH_RISE: assert property ( // [RULE2] [RULE11]
			(det_armed && !fall_sel[gc] && !det_prev[gc] && ext_irq_pin[gc]) |-> raw_hit[gc])
			else $error("selected rising edge not detected");

		AST_CH_FALL: assert property ( // [RULE2] [RULE11]
			(det_armed && fall_sel[gc] && det_prev[gc] && !ext_irq_pin[gc]) |-> raw_hit[gc])
			else $error("selected falling edge not detected");

		AST_CH_WRONG_DIR: assert property ( // [RULE2] [RULE11]
			(ext_irq_pin[gc] == fall_sel[gc] || ext_irq_pin[gc] == det_prev[gc]) |-> !raw_hit[gc])
			else $error("edge reported for an unselected direction or a steady pin");
	end

endmodule : peil_top

// ### peil_consts.svh
// Purpose: named constants of the port external interrupt logic
// Assumes: included by its bare name wherever a constant is used
// Notes: definitions only
`ifndef PEIL_CONSTS_SVH
`define PEIL_CONSTS_SVH

// data and address widths
`define PEIL_W 8
`define PEIL_AW 3

// register addresses
`define PEIL_ADDR_ENABLE 3'h0
`define PEIL_ADDR_FLAG 3'h1
`define PEIL_ADDR_EDGE 3'h2
`define PEIL_ADDR_STAT 3'h3
`define PEIL_ADDR_CLEAR 3'h4
`define PEIL_ADDR_IEN 3'h5

// reset values
`define PEIL_RST_ENABLE 8'h00
`define PEIL_RST_FLAG 8'h00
`define PEIL_RST_EDGE 8'h00
`define PEIL_RST_STAT 8'h00
`define PEIL_RST_IEN 8'h00
`define PEIL_RST_RDATA 8'h00
`define PEIL_RST_PREV 8'h00

// six-channel enable register layout
`define PEIL_SEL_HI_BIT 7
`define PEIL_SEL_LO_BIT 6
`define PEIL_LO_GRP_N 2

// channels that exist in each variant
`define PEIL_MASK_SIX 8'h3F
`define PEIL_MASK_EIGHT 8'hFF

`endif

// ### peil_pkg.sv
// Purpose: types shared by the port external interrupt logic
// Assumes: constants come from peil_consts.svh
// Notes: types only
`include "peil_consts.svh"

package peil_pkg;

	typedef enum logic [1:0] {
		PEIL_SIX = 2'b01,
		PEIL_EIGHT = 2'b10
	} peil_variant_t;

	typedef struct packed {
		logic [`PEIL_W-1:0] prev;
		logic armed;
	} peil_det_st_t;

	typedef struct packed {
		logic [`PEIL_W-1:0] en;
		logic [`PEIL_W-1:0] flag;
		logic [`PEIL_W-1:0] edge_sel;
		logic [`PEIL_W-1:0] stat;
		logic [`PEIL_W-1:0] ien;
		logic [`PEIL_W-1:0] rdata;
	} peil_st_t;

endpackage : peil_pkg

// ### peil_edge_det.sv
// Purpose: per-pin edge detector against the previous clock sample
// Assumes: pins are synchronous to clk
// Notes: no hit in the first enabled cycle after reset, the sample is not yet valid
`timescale 1ns/1ps
`include "peil_consts.svh"

module peil_edge_det (
	// clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// pins and per-pin edge select, 1 selects falling
	input wire logic [`PEIL_W-1:0] pin,
	input wire logic [`PEIL_W-1:0] fall_sel,
	// detected edges and the sample they were judged against
	output logic [`PEIL_W-1:0] hit,
	output logic [`PEIL_W-1:0] prev,
	output logic armed
);
	import peil_pkg::*;

	peil_det_st_t st_r;
	peil_det_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.prev = pin; // [RULE15]
			st_nxt.armed = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r.prev <= `PEIL_RST_PREV;
			st_r.armed <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// a pin high out of reset must not look like a rising edge
	for (genvar gi = 0; gi < `PEIL_W; gi++) begin : g_hit
		assign hit[gi] = st_r.armed & (fall_sel[gi] ? (st_r.prev[gi] & ~pin[gi])
			: (~st_r.prev[gi] & pin[gi])); // [RULE15]
	end

	assign prev = st_r.prev;
	assign armed = st_r.armed;

endmodule : peil_edge_det

// ### peil_pin_src.sv
// Purpose: external sources driving the interrupt-capable port pins
// Assumes: sources change only right after a rising clk edge
// Notes: a source cannot glitch; narrower pulses would be missed by the sampler
`timescale 1ns/1ps

module peil_pin_src (
	// clock
	input wire logic clk,
	// requested levels and driven pins
	input wire logic [7:0] want,
	output logic [7:0] pin
);
	initial pin = 8'h00;
	// each level stands at least one full clock so it is sampled
	always @(posedge clk) begin
		pin <= want;
	end
endmodule : peil_pin_src

// ### tb_peil_top.sv
// Purpose: self-checking bench for both variants of the port external interrupt logic
// Assumes: one register master and one pin source shared by both variants
// Notes: pin waits are fixed: one cycle in the source, one to detect the edge
`timescale 1ns/1ps
`include "peil_consts.svh"

module tb_peil_top;
	import peil_pkg::*;
	logic clk, nrst, ce, wr, rd, req6, req8, irq6, irq8;
	logic [`PEIL_AW-1:0] addr;
	logic [`PEIL_W-1:0] wdata, want, pin, rd6, rd8;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;

	peil_pin_src src (.clk(clk), .want(want), .pin(pin));
	peil_top #(.VARIANT(PEIL_SIX)) dut (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rd6), .ext_irq_pin(pin),
		.ext_irq_req(req6), .irq(irq6));
	peil_top #(.VARIANT(PEIL_EIGHT)) dut_eight (.clk(clk), .nrst(nrst), .ce(ce),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rd8), .ext_irq_pin(pin),
		.ext_irq_req(req8), .irq(irq8));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic finish_test();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic chk(input string what, input logic [7:0] e6, input logic [7:0] e8,
		input logic [7:0] g6, input logic [7:0] g8);
		total_checks += 2;
		if (g6 !== e6) begin
			error_cnt++;
			$display("mismatch %s six expected %h seen %h", what, e6, g6);
		end
		if (g8 !== e8) begin
			error_cnt++;
			$display("mismatch %s eight expected %h seen %h", what, e8, g8);
		end
	endtask : chk

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e6, input logic [7:0] e8);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", e6, e8, rd6, rd8);
	endtask : rd_chk

	task automatic req_chk(input logic e6, input logic e8);
		#1;
		chk("ext_irq_req", {7'h00, e6}, {7'h00, e8}, {7'h00, req6}, {7'h00, req8});
	endtask : req_chk

	task automatic irq_chk(input logic e6, input logic e8);
		#1;
		chk("irq", {7'h00, e6}, {7'h00, e8}, {7'h00, irq6}, {7'h00, irq8});
	endtask : irq_chk

	task automatic pins(input logic [7:0] v);
		@(posedge clk);
		want <= v;
		repeat (2) @(posedge clk);
	endtask : pins

	// reset values, unmapped reads, and writes ignored while frozen
	task automatic t_reset();
		for (int a = 0; a < 8; a++) begin
			rd_chk(a[2:0], 8'h00, 8'h00);
		end
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(`PEIL_ADDR_ENABLE, 8'hFF);
		@(posedge clk);
		ce <= 1'b1;
		rd_chk(`PEIL_ADDR_ENABLE, 8'h00, 8'h00);
	endtask : t_reset

	// rising edges on all pins; six-channel sets only its six flags
	task automatic t_rise();
		wr_reg(`PEIL_ADDR_ENABLE, 8'h3F);
		pins(8'hFF);
		rd_chk(`PEIL_ADDR_FLAG, 8'h3F, 8'hFF);
		req_chk(1'b1, 1'b1);
		rd_chk(`PEIL_ADDR_STAT, 8'h3F, 8'hFF);
	endtask : t_rise

	// status: masked, unmasked, then cleared
	task automatic t_irq();
		irq_chk(1'b0, 1'b0);
		wr_reg(`PEIL_ADDR_IEN, 8'h01);
		irq_chk(1'b1, 1'b1);
		wr_reg(`PEIL_ADDR_CLEAR, 8'hFF);
		irq_chk(1'b0, 1'b0);
		rd_chk(`PEIL_ADDR_STAT, 8'h00, 8'h00);
		rd_chk(`PEIL_ADDR_CLEAR, 8'h00, 8'h00);
	endtask : t_irq

	// shared selects split low pair and upper group; per-pin selects alternate
	task automatic t_select();
		wr_reg(`PEIL_ADDR_FLAG, 8'h00);
		rd_chk(`PEIL_ADDR_FLAG, 8'h00, 8'h00);
		wr_reg(`PEIL_ADDR_ENABLE, 8'hBF);
		wr_reg(`PEIL_ADDR_EDGE, 8'hAA);
		rd_chk(`PEIL_ADDR_EDGE, 8'h00, 8'hAA);
		pins(8'h00);
		rd_chk(`PEIL_ADDR_FLAG, 8'h3C, 8'hAA);
		pins(8'hFF);
		rd_chk(`PEIL_ADDR_FLAG, 8'h3F, 8'hFF);
	endtask : t_select

	// software set, held while nothing happens, per-channel enables
	task automatic t_sw_set();
		wr_reg(`PEIL_ADDR_ENABLE, 8'h00);
		wr_reg(`PEIL_ADDR_FLAG, 8'hC1);
		rd_chk(`PEIL_ADDR_FLAG, 8'h01, 8'hC1);
		req_chk(1'b0, 1'b0);
		wr_reg(`PEIL_ADDR_ENABLE, 8'h01);
		req_chk(1'b1, 1'b1);
		repeat (5) @(posedge clk);
		rd_chk(`PEIL_ADDR_FLAG, 8'h01, 8'hC1);
		wr_reg(`PEIL_ADDR_FLAG, 8'h40);
		wr_reg(`PEIL_ADDR_ENABLE, 8'h40);
		req_chk(1'b0, 1'b1);
		wr_reg(`PEIL_ADDR_FLAG, 8'h00);
		req_chk(1'b0, 1'b0);
	endtask : t_sw_set

	// a clearing write in the very cycle an edge is seen loses to the edge
	task automatic t_set_wins();
		@(posedge clk);
		want <= 8'h00;
		wr_reg(`PEIL_ADDR_FLAG, 8'h00);
		rd_chk(`PEIL_ADDR_FLAG, 8'h03, 8'hAA);
	endtask : t_set_wins

	initial begin
		ce = 1'b1;
		nrst = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		want = 8'h00;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_rise();
		t_irq();
		t_select();
		t_sw_set();
		t_set_wins();
		finish_test();
	end
endmodule : tb_peil_top
